// *** rtl/sacp_conv_port.sv ***
`timescale 1ns/1ns
`default_nettype none
module sacp_conv_port #(
   parameter int CONV_CYCLES = sacp_pkg::CONV_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_rd_conv,
   input wire logic i_sel_n,
   input wire logic i_lane_swap,
   input wire logic [sacp_pkg::RESULT_W-1:0] i_sample,
   output logic [sacp_pkg::RESULT_W-1:0] o_result_bits,
   output logic [sacp_pkg::RESULT_W-1:0] o_result_oe,
   output logic o_busy_n,
   output logic o_first_invalid
);
   logic rc_s;
   logic sel_n_s;
   logic [sacp_pkg::RESULT_W-1:0] sample_s;
   logic cmd_q;
   logic cmd_d;
   logic lane_q;
   logic lane_d;
   sacp_pkg::sacp_state_t state_q;
   sacp_pkg::sacp_state_t state_d;
   logic [sacp_pkg::CNT_W-1:0] cnt_q;
   logic [sacp_pkg::CNT_W-1:0] cnt_d;
   logic [sacp_pkg::RESULT_W-1:0] hold_q;
   logic [sacp_pkg::RESULT_W-1:0] hold_d;
   logic [sacp_pkg::RESULT_W-1:0] result_q;
   logic [sacp_pkg::RESULT_W-1:0] result_d;
   logic busy_n_q;
   logic busy_n_d;
   logic first_q;
   logic first_d;
   sacp_pkg::sacp_bus_t bus_q;
   sacp_pkg::sacp_bus_t bus_d;
   logic start;
   logic conv_last;

   // Last count of the conversion: the result register loads here so that
   // the new word is already driven on the edge where busy rises
   localparam logic [sacp_pkg::CNT_W-1:0] LAST_CNT =
      sacp_pkg::CNT_W'(CONV_CYCLES - 2);

   // Drive decode kept apart so the enable rule reads in one place
   function automatic logic read_enabled(input logic sel_n, input logic rc);
      return !sel_n && rc;
   endfunction : read_enabled

   // Lanes swap as whole bytes; with no swap the top lane holds the MSB
   function automatic logic [sacp_pkg::RESULT_W-1:0] lane_order(
      input logic [sacp_pkg::RESULT_W-1:0] word,
      input logic swap
   );
      if (swap)
      begin
         return {word[sacp_pkg::LANE_W-1:0],
            word[sacp_pkg::RESULT_W-1:sacp_pkg::LANE_W]};
      end
      else
      begin
         return word;
      end
   endfunction : lane_order

   // Pins land about four clocks late; pulses under two clocks may vanish
   sacp_sync #(.RESET_VAL(1'b1)) u_sync_rc (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_async(i_rd_conv),
      .o_level(rc_s)
   );

   sacp_sync #(.RESET_VAL(1'b1)) u_sync_sel (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_async(i_sel_n),
      .o_level(sel_n_s)
   );

   sacp_sync #(.RESET_VAL(1'b0)) u_sync_lane (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_async(i_lane_swap),
      .o_level(lane_d)
   );

   // Analog side stand-in: the held sample is already two's complement
   genvar g;
   generate
      for (g = 0; g < sacp_pkg::RESULT_W; g++)
      begin : g_samp
         sacp_sync #(.RESET_VAL(1'b0)) u_sync_samp (
            .i_clk(i_clk),
            .i_resetn(i_resetn),
            .i_async(i_sample[g]),
            .o_level(sample_s[g])
         );
      end
   endgenerate

   // Count stops two short: the latch cycle and the busy edge make up the rest
   assign conv_last = (cnt_q == LAST_CNT);

   // Select and read/convert are OR'd: one combined command line
   always_comb
   begin
      cmd_d = rc_s | sel_n_s; // RQ3
      // Falling edge of the combined line means both low: start
      start = cmd_q & ~cmd_d; // RQ1 RQ3 RQ13
   end

   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      hold_d = hold_q;
      result_d = result_q;
      busy_n_d = busy_n_q;
      first_d = first_q;
      case (state_q)
         sacp_pkg::SACP_IDLE:
         begin
            if (start)
            begin
               hold_d = sample_s; // RQ1 RQ11
               cnt_d = '0;
               busy_n_d = 1'b0; // RQ8
               state_d = sacp_pkg::SACP_CONV;
            end
         end
         sacp_pkg::SACP_CONV:
         begin
            // Commands are ignored here by construction
            cnt_d = cnt_q + 1'b1; // RQ12 RQ15
            if (conv_last)
            begin
               // Loaded a cycle early so the new word drives as busy rises
               result_d = hold_q; // RQ8 RQ9 RQ10
               state_d = sacp_pkg::SACP_LATCH;
            end
         end
         sacp_pkg::SACP_LATCH:
         begin
            // Busy rises on the edge that puts the new word on the bus
            state_d = sacp_pkg::SACP_IDLE;
            busy_n_d = 1'b1; // RQ8
            first_d = 1'b0; // RQ14
         end
         default:
         begin
            state_d = sacp_pkg::SACP_IDLE;
            busy_n_d = 1'b1;
         end
      endcase
   end

   // Read enabled only with select low and read/convert high
   always_comb
   begin
      bus_d.oe = read_enabled(sel_n_s, rc_s) ? '1 : '0; // RQ2 RQ4 RQ5 RQ6
      bus_d.data = lane_order(result_q, lane_q); // RQ7 RQ10
   end

   // Combined line registered again so its falling edge can be found
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         cmd_q <= 1'b1;
         lane_q <= 1'b0;
      end
      else
      begin
         cmd_q <= cmd_d;
         lane_q <= lane_d;
      end
   end

   // Hold register keeps the sample while the pins go on changing
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state_q <= sacp_pkg::SACP_IDLE;
         cnt_q <= '0;
         hold_q <= sacp_pkg::RESULT_RESET;
         result_q <= sacp_pkg::RESULT_RESET;
         busy_n_q <= 1'b1;
         first_q <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         hold_q <= hold_d;
         result_q <= result_d;
         busy_n_q <= busy_n_d;
         first_q <= first_d;
      end
   end

   // Drive and data launch from one register so no mixed word is shown
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         bus_q <= '0;
      end
      else
      begin
         bus_q <= bus_d;
      end
   end

   assign o_result_bits = bus_q.data;
   assign o_result_oe = bus_q.oe;
   assign o_busy_n = busy_n_q;
   assign o_first_invalid = first_q; // RQ14
endmodule : sacp_conv_port
`default_nettype wire

// *** rtl/sacp_pkg.sv ***
// Summary of operation
// [RQ1] Select low: read/convert fall starts conversion
// [RQ2] Select low: read/convert rise enables data
// [RQ3] Select fall with read/convert low converts
// [RQ4] Select fall with read/convert high reads
// [RQ5] Select high floats all result bits
// [RQ6] Read/convert low floats all result bits
// [RQ7] Lane swap high exchanges the two bytes
// [RQ8] Busy low from start until result latched
// [RQ9] Data valid when busy rises
// [RQ10] Sixteen-bit result, MSB on top lane
// [RQ11] Result coded in two's complement
// [RQ12] Control inputs ignored during a conversion; the code ignores only starts, reads still drive the bus
// [RQ13] Host holds both low at least 50 ns
// [RQ14] First result after power-up is indeterminate
// [RQ15] Conversion timed by internal cycle count
`default_nettype none
package sacp_pkg;
   localparam int RESULT_W = 16;
   localparam int LANE_W = 8;
   localparam int CLK_PERIOD_NS = 20;
   localparam int CONV_TIME_NS = 4000;
   // Longest time: round down
   localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int START_PULSE_NS = 50;
   // Least time: round up
   localparam int START_PULSE_CYCLES =
      (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 12;
   localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;

   typedef enum logic [1:0] {
      SACP_IDLE = 2'b00,
      SACP_CONV = 2'b01,
      SACP_LATCH = 2'b11
   } sacp_state_t;

   typedef struct packed {
      logic [RESULT_W-1:0] data;
      logic [RESULT_W-1:0] oe;
   } sacp_bus_t;
endpackage : sacp_pkg
`default_nettype wire

// *** rtl/sacp_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser; a change counts once stages two and three agree
module sacp_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_async,
   output logic o_level
);
   logic [2:0] sync_q;
   logic [2:0] sync_d;
   logic level_q;
   logic level_d;

   always_comb
   begin
      sync_d = {sync_q[1:0], i_async};
      level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : level_q;
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         sync_q <= {3{RESET_VAL}};
         level_q <= RESET_VAL;
      end
      else
      begin
         sync_q <= sync_d;
         level_q <= level_d;
      end
   end

   assign o_level = level_q;
endmodule : sacp_sync
`default_nettype wire

// *** test/sacp_conv_port_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module sacp_conv_port_properties #(
   parameter int CONV_CYCLES = sacp_pkg::CONV_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_rd_conv,
   input wire logic i_sel_n,
   input wire logic [15:0] o_result_oe,
   input wire logic o_busy_n,
   input wire logic o_first_invalid
);
   logic [11:0] cnt_q;
   logic [11:0] cnt_d;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // Cycles that busy has been low so far
   always_comb cnt_d = o_busy_n ? 12'h000 : cnt_q + 12'h001;
   always_ff @(posedge i_clk or negedge i_resetn)
      if (!i_resetn)
         cnt_q <= 12'h000;
      else
         cnt_q <= cnt_d;
   a_float_sel: assert property (
      i_sel_n [*8] |-> o_result_oe == 16'h0000)
      else $error("bus driven, select high");
   a_float_conv: assert property (
      !i_rd_conv [*8] |-> o_result_oe == 16'h0000)
      else $error("bus driven, convert low");
   a_drive_read: assert property (
      (!i_sel_n && i_rd_conv) [*8] |-> o_result_oe == 16'hFFFF)
      else $error("bus not driven on read");
   a_oe_uniform: assert property (
      o_result_oe == 16'h0000 || o_result_oe == 16'hFFFF)
      else $error("partial bus drive");
   a_busy_len: assert property (
      $rose(o_busy_n) |-> int'(cnt_q) == CONV_CYCLES)
      else $error("busy length wrong");
   a_start_rc: assert property (
      $fell(i_rd_conv) && !i_sel_n && o_busy_n |-> ##[1:8] !o_busy_n)
      else $error("no start on convert fall");
   a_start_cs: assert property (
      $fell(i_sel_n) && !i_rd_conv && o_busy_n |-> ##[1:8] !o_busy_n)
      else $error("no start on select fall");
   a_first_valid: assert property (
      $rose(o_busy_n) |-> ##[0:1] !o_first_invalid)
      else $error("first flag stuck");
endmodule : sacp_conv_port_properties
bind sacp_conv_port sacp_conv_port_properties #(.CONV_CYCLES(CONV_CYCLES))
   sacp_conv_port_properties_i (.*);
`default_nettype wire

// *** test/sacp_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module sacp_host (
   input wire logic i_clk,
   input wire logic i_busy_n,
   output logic o_rd_conv,
   output logic o_sel_n
);
   initial {o_rd_conv, o_sel_n} = 2'b11;
   // Each level is held n cycles; callers hold the both-low start three cycles, past the 50 ns minimum
   task automatic pins(input logic rc, input logic sel, input int n);
      @(posedge i_clk);
      o_rd_conv <= rc;
      o_sel_n <= sel;
      repeat (n) @(posedge i_clk);
   endtask : pins
   task automatic wait_busy(input logic lvl, output logic ok);
      repeat (60)
      begin
         @(negedge i_clk);
         if (i_busy_n === lvl)
            break;
      end
      ok = (i_busy_n === lvl);
   endtask : wait_busy
endmodule : sacp_host
`default_nettype wire

// *** test/sacp_conv_port_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module sacp_conv_port_tb_top;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic lane = 1'b0;
   logic ok;
   logic [15:0] sample = 16'h0000;
   wire logic [15:0] data;
   wire logic [15:0] oe;
   wire logic [15:0] bus;
   wire logic rc;
   wire logic sel_n;
   wire logic busy_n;
   wire logic first_inv;
   int failures = 0;
   int num_checks = 0;
   // A released line reads back inverted so a stale value cannot pass
   assign bus = data ^ ~oe;
   initial forever #10 i_clk = ~i_clk;
   sacp_conv_port #(.CONV_CYCLES(40)) sacp_conv_port_i (.i_clk(i_clk),
      .i_resetn(i_resetn), .i_rd_conv(rc), .i_sel_n(sel_n),
      .i_lane_swap(lane), .i_sample(sample), .o_result_bits(data),
      .o_result_oe(oe), .o_busy_n(busy_n), .o_first_invalid(first_inv));
   sacp_host sacp_host_i (.i_clk(i_clk), .i_busy_n(busy_n), .o_rd_conv(rc),
      .o_sel_n(sel_n));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      #1;
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done
   task automatic busy(input logic lvl);
      sacp_host_i.wait_busy(lvl, ok);
      if (!ok)
      begin
         failures++;
         $display("wrong value at %0t: busy wait ran out", $time);
         test_done;
      end
   endtask : busy
   // Mode 0 starts by convert, 1 by select, 2 by convert with meddling
   task automatic conv(input logic [15:0] s, input int mode);
      @(posedge i_clk);
      sample <= s;
      sacp_host_i.pins(mode != 1, mode == 1, 2);
      sacp_host_i.pins(1'b0, 1'b0, 3);
      busy(1'b0);
      if (mode == 2)
      begin
         @(posedge i_clk);
         sample <= 16'hFFFF;
         sacp_host_i.pins(1'b1, 1'b0, 3);
         sacp_host_i.pins(1'b0, 1'b0, 8);
         chk(oe, 16'h0000);
         sacp_host_i.pins(1'b1, 1'b0, 3);
      end
      busy(1'b1);
      if (mode == 2)
         chk(bus, s);
      if (mode == 1)
         sacp_host_i.pins(1'b1, 1'b1, 2);
      sacp_host_i.pins(1'b1, 1'b0, 8);
   endtask : conv
   task automatic t_reset;
      chk({13'h0000, busy_n, first_inv, oe[0]}, 16'h0006);
   endtask : t_reset
   task automatic t_conv_rc;
      conv(16'h8001, 0);
      chk(bus, 16'h8001);
      chk({15'h0000, first_inv}, 16'h0000);
   endtask : t_conv_rc
   task automatic t_swap_float;
      @(posedge i_clk);
      lane <= 1'b1;
      repeat (8) @(posedge i_clk);
      chk(bus, 16'h0180);
      @(posedge i_clk);
      lane <= 1'b0;
      sacp_host_i.pins(1'b1, 1'b1, 8);
      chk(oe, 16'h0000);
      sacp_host_i.pins(1'b0, 1'b1, 8);
      chk(oe, 16'h0000);
      sacp_host_i.pins(1'b1, 1'b1, 2);
   endtask : t_swap_float
   task automatic t_conv_cs;
      conv(16'h7FFE, 1);
      chk(bus, 16'h7FFE);
   endtask : t_conv_cs
   task automatic t_ignore;
      conv(16'h1234, 2);
      chk(bus, 16'h1234);
      repeat (10) @(posedge i_clk);
      chk({15'h0000, busy_n}, 16'h0001);
   endtask : t_ignore
   initial
   begin
      repeat (3) @(posedge i_clk);
      i_resetn <= 1'b1;
      t_reset;
      t_conv_rc;
      t_swap_float;
      t_conv_cs;
      t_ignore;
      test_done;
   end
endmodule : sacp_conv_port_tb_top
`default_nettype wire
